/* File: design/hidled_regs.svh */
// Register offsets, fields, reset values and timing counts of the lamp block
`ifndef HIDLED_REGS_SVH
`define HIDLED_REGS_SVH

`define HIDLED_CONFIG_OFFSET  8'h00
`define HIDLED_STATUS_OFFSET  8'h04
`define HIDLED_IRQ_STAT_OFFSET 8'h08
`define HIDLED_IRQ_MASK_OFFSET 8'h0c

`define HIDLED_CFG_CONFIGURED 0
`define HIDLED_CFG_FORCE_ERR  1
`define HIDLED_CONFIG_RESET   2'h0

`define HIDLED_IRQ_FAIL       0
`define HIDLED_IRQ_FIELD      1
`define HIDLED_IRQ_COMM       2
`define HIDLED_IRQ_WIDTH      3

`define HIDLED_CLK_HZ         10000000
`define HIDLED_COMM_TIMEOUT_MS 100
`define HIDLED_EOC_TIMEOUT_MS 50
`define HIDLED_FLASH_HALF_MS  250
`define HIDLED_MS_CYCLES(ms) ((ms) * (`HIDLED_CLK_HZ / 1000))

`endif

/* File: design/hidled_pkg.sv */
// Types shared by the lamp block
package hidled_pkg;
	typedef struct packed {
		logic       comm_ok;
		logic       ext_fault;
		logic       int_fault;
		logic [7:0] chan;
	} hidled_lamps_type;

	typedef struct packed {
		logic       request;
		logic       reply_ok;
		logic       fail;
		logic [2:0] channel;
	} hidled_hart_type;

	typedef struct packed {
		logic ref_err;
		logic gnd_err;
		logic flash_err;
		logic ee_err;
		logic ram_err;
	} hidled_diag_type;
endpackage : hidled_pkg

/* File: design/hidled_watchdog.sv */
// Activity watchdog: flags a timeout when no activity pulse arrives in time
`timescale 1ns/10ps
`default_nettype none
module hidled_watchdog #(
	parameter int LIMIT = 1000
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	input  wire logic ce,
	input  wire logic activity,
	output var  logic expired
);
	localparam int W = $clog2(LIMIT + 1);
	logic [W-1:0] count;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count   <= '0;
			expired <= 1'b1;
		end else if (ce) begin
			if (activity) begin
				count   <= '0;
				expired <= 1'b0;
			end else if (count == W'(LIMIT - 1)) begin
				expired <= 1'b1;
			end else begin
				count <= count + W'(1);
			end
		end
	end
endmodule : hidled_watchdog
`default_nettype wire

/* File: design/hidled_top.sv */
// Diagnostic lamp logic with an AXI4-Lite register slave
//
// The register offsets and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
`include "hidled_regs.svh"
module hidled_top #(
	parameter int COMM_CYCLES  = `HIDLED_MS_CYCLES(`HIDLED_COMM_TIMEOUT_MS),
	parameter int EOC_CYCLES   = `HIDLED_MS_CYCLES(`HIDLED_EOC_TIMEOUT_MS),
	parameter int FLASH_CYCLES = `HIDLED_MS_CYCLES(`HIDLED_FLASH_HALF_MS)
) (
	input  wire logic                         aclk,
	input  wire logic                         aresetn,
	input  wire logic                         ce,
	input  wire logic                         ctrl_activity,
	input  wire logic                         eoc,
	input  wire hidled_pkg::hidled_diag_type  diag,
	input  wire hidled_pkg::hidled_hart_type  hart,
	output var  hidled_pkg::hidled_lamps_type lamps,
	output var  logic                         irq,
	input  wire logic [7:0]                   s_axi_awaddr,
	input  wire logic                         s_axi_awvalid,
	output var  logic                         s_axi_awready,
	input  wire logic [31:0]                  s_axi_wdata,
	input  wire logic [3:0]                   s_axi_wstrb,
	input  wire logic                         s_axi_wvalid,
	output var  logic                         s_axi_wready,
	output var  logic [1:0]                   s_axi_bresp,
	output var  logic                         s_axi_bvalid,
	input  wire logic                         s_axi_bready,
	input  wire logic [7:0]                   s_axi_araddr,
	input  wire logic                         s_axi_arvalid,
	output var  logic                         s_axi_arready,
	output var  logic [31:0]                  s_axi_rdata,
	output var  logic [1:0]                   s_axi_rresp,
	output var  logic                         s_axi_rvalid,
	input  wire logic                         s_axi_rready
);
	import hidled_pkg::*;

	typedef enum logic [1:0] {CH_IDLE, CH_WAIT, CH_FAIL} hidled_chan_type;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam int         FW = $clog2(FLASH_CYCLES + 1);

	logic                          configured;
	logic                          force_err;
	logic [`HIDLED_IRQ_WIDTH-1:0]  irq_stat;
	logic [`HIDLED_IRQ_WIDTH-1:0]  irq_mask;
	logic [`HIDLED_IRQ_WIDTH-1:0]  next_irq_stat;
	logic                          comm_lost;
	logic                          field_lost;
	logic                          eoc_prev;
	logic                          eoc_edge;
	logic                          comm_lost_prev;
	logic                          field_lost_prev;
	logic                          int_err;
	hidled_chan_type               chan_state;
	logic [7:0]                    chan_sel;
	logic [FW-1:0]                 flash_cnt;
	logic                          flash_phase;
	logic [7:0]                    next_chan;

	logic [7:0]  aw_addr;
	logic        aw_held;
	logic [31:0] w_data;
	logic [3:0]  w_strb;
	logic        w_held;
	logic        do_write;
	logic        wr_cfg;
	logic        wr_clr;
	logic        wr_mask;
	logic [31:0] rd_word;

	// Watchdogs on controller traffic and on the conversion strobe
	hidled_watchdog #(.LIMIT(COMM_CYCLES)) u_comm_wd (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.activity (ctrl_activity),
		.expired  (comm_lost)
	);

	assign eoc_edge = eoc ^ eoc_prev;

	// A stuck strobe means the field converter lost its supply
	hidled_watchdog #(.LIMIT(EOC_CYCLES)) u_eoc_wd (
		.aclk     (aclk),
		.aresetn  (aresetn),
		.ce       (ce),
		.activity (eoc_edge),
		.expired  (field_lost)
	);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			eoc_prev        <= eoc; // No false edge after reset
			comm_lost_prev  <= 1'b1;
			field_lost_prev <= 1'b1;
		end else if (ce) begin
			eoc_prev        <= eoc;
			comm_lost_prev  <= comm_lost;
			field_lost_prev <= field_lost;
		end
	end

	// AXI4-Lite write side: address and data accepted in either order
	assign do_write = aw_held && w_held && !s_axi_bvalid;
	assign wr_cfg   = do_write && aw_addr == `HIDLED_CONFIG_OFFSET;
	assign wr_clr   = do_write && aw_addr == `HIDLED_IRQ_STAT_OFFSET;
	assign wr_mask  = do_write && aw_addr == `HIDLED_IRQ_MASK_OFFSET;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held       <= 1'b0;
			w_held        <= 1'b0;
			aw_addr       <= 8'h00;
			w_data        <= 32'h0000_0000;
			w_strb        <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= RESP_OKAY;
		end else if (ce) begin
			s_axi_awready <= !aw_held && !s_axi_awready;
			s_axi_wready  <= !w_held && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_held       <= 1'b1;
				aw_addr       <= s_axi_awaddr;
				s_axi_awready <= 1'b0;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_held       <= 1'b1;
				w_data       <= s_axi_wdata;
				w_strb       <= s_axi_wstrb;
				s_axi_wready <= 1'b0;
			end
			if (do_write) begin
				aw_held      <= 1'b0;
				w_held       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (wr_cfg || wr_clr || wr_mask ||
					aw_addr == `HIDLED_STATUS_OFFSET) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// Configuration register; only the low byte lane carries fields
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			configured <= 1'b0;
			force_err  <= 1'b0;
		end else if (ce && wr_cfg && w_strb[0]) begin
			configured <= w_data[`HIDLED_CFG_CONFIGURED];
			force_err  <= w_data[`HIDLED_CFG_FORCE_ERR];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_mask <= '0;
		end else if (ce && wr_mask && w_strb[0]) begin
			irq_mask <= w_data[`HIDLED_IRQ_WIDTH-1:0];
		end
	end

	// Sticky events; a new event beats a clear in the same cycle
	always_comb begin
		next_irq_stat = irq_stat;
		if (wr_clr && w_strb[0]) begin
			next_irq_stat = irq_stat & ~w_data[`HIDLED_IRQ_WIDTH-1:0];
		end
		if (chan_state == CH_WAIT && hart.fail) begin
			next_irq_stat[`HIDLED_IRQ_FAIL] = 1'b1;
		end
		if (field_lost && !field_lost_prev) begin
			next_irq_stat[`HIDLED_IRQ_FIELD] = 1'b1;
		end
		if (comm_lost && !comm_lost_prev) begin
			next_irq_stat[`HIDLED_IRQ_COMM] = 1'b1;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat <= '0;
			irq      <= 1'b0;
		end else if (ce) begin
			irq_stat <= next_irq_stat;
			irq      <= |(next_irq_stat & irq_mask);
		end
	end

	// AXI4-Lite read side
	always_comb begin
		rd_word = 32'h0000_0000;
		case (s_axi_araddr)
			`HIDLED_CONFIG_OFFSET: begin
				rd_word[`HIDLED_CFG_CONFIGURED] = configured;
				rd_word[`HIDLED_CFG_FORCE_ERR]  = int_err;
			end
			`HIDLED_STATUS_OFFSET: begin
				rd_word[10:0] = {lamps.comm_ok, lamps.ext_fault,
					lamps.int_fault, lamps.chan};
			end
			`HIDLED_IRQ_STAT_OFFSET: begin
				rd_word[`HIDLED_IRQ_WIDTH-1:0] = irq_stat;
			end
			`HIDLED_IRQ_MASK_OFFSET: begin
				rd_word[`HIDLED_IRQ_WIDTH-1:0] = irq_mask;
			end
			default: begin
				rd_word = 32'h0000_0000;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (ce) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_arready <= 1'b0;
				s_axi_rvalid  <= 1'b1;
				s_axi_rdata   <= rd_word;
				s_axi_rresp   <= (s_axi_araddr[7:4] == 4'h0 &&
					s_axi_araddr[1:0] == 2'h0) ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Every internal error except field supply loss
	assign int_err = force_err || comm_lost ||
		diag.ref_err || diag.gnd_err || diag.flash_err ||
		diag.ee_err || diag.ram_err;

	// Channel activity sequencer
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			chan_state <= CH_IDLE;
			chan_sel   <= 8'h00;
		end else if (ce) begin
			if (!configured) begin
				chan_state <= CH_IDLE;
				chan_sel   <= 8'h00;
			end else if (hart.request) begin
				chan_state <= CH_WAIT;
				chan_sel   <= 8'h01 << hart.channel;
			end else begin
				case (chan_state)
					CH_WAIT: begin
						if (hart.reply_ok) begin
							chan_state <= CH_IDLE;
						end else if (hart.fail) begin
							chan_state <= CH_FAIL;
						end
					end
					CH_FAIL: begin
						chan_state <= CH_FAIL;
					end
					default: begin
						chan_state <= CH_IDLE;
					end
				endcase
			end
		end
	end

	// Flash timing for the failure pattern
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			flash_cnt   <= '0;
			flash_phase <= 1'b1;
		end else if (ce) begin
			if (chan_state != CH_FAIL) begin
				flash_cnt   <= '0;
				flash_phase <= 1'b1;
			end else if (flash_cnt == FW'(FLASH_CYCLES - 1)) begin
				flash_cnt   <= '0;
				flash_phase <= !flash_phase;
			end else begin
				flash_cnt <= flash_cnt + FW'(1);
			end
		end
	end

	always_comb begin
		case (chan_state)
			CH_WAIT: next_chan = chan_sel;
			CH_FAIL: next_chan = flash_phase ? (chan_sel ^ 8'hff) : 8'h00;
			default: next_chan = 8'h00;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			lamps <= '0;
		end else if (ce) begin
			lamps.comm_ok   <= !comm_lost;
			lamps.ext_fault <= field_lost;
			lamps.int_fault <= int_err;
			lamps.chan      <= configured ? next_chan : 8'h00;
		end
	end

	a_comm_lamp_tracks: assert property (@(posedge aclk)
		disable iff (!aresetn) ce |=> lamps.comm_ok == !$past(comm_lost))
		else $error("comm lamp does not follow controller activity");
	a_ext_lamp_field: assert property (@(posedge aclk)
		disable iff (!aresetn) ce && field_lost |=> lamps.ext_fault)
		else $error("field loss not shown on external lamp");
	a_int_excl_field: assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce && field_lost && !int_err |=> !lamps.int_fault)
		else $error("field loss leaked to internal lamp");
	a_int_force_comm: assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce && (force_err || comm_lost) |=> lamps.int_fault)
		else $error("forced or comm error not on internal lamp");
	a_int_diag_err: assert property (@(posedge aclk)
		disable iff (!aresetn) ce && diag != '0 |=> lamps.int_fault)
		else $error("diagnostic error not on internal lamp");
	a_unconfig_dark: assert property (@(posedge aclk)
		disable iff (!aresetn) ce && !configured |=> lamps.chan == 8'h00)
		else $error("channel lamps active before configuration");
	sequence s_request;
		ce && configured && hart.request;
	endsequence
	sequence s_reply;
		ce && chan_state == CH_WAIT && hart.reply_ok && !hart.request;
	endsequence
	a_request_one_hot: assert property (@(posedge aclk)
		disable iff (!aresetn)
		s_request ##1 (ce && configured) |=>
		lamps.chan == (8'h01 << $past(hart.channel, 2)))
		else $error("request lamp is not one-hot on its channel");
	a_reply_clears: assert property (@(posedge aclk)
		disable iff (!aresetn) s_reply ##1 ce |=> lamps.chan == 8'h00)
		else $error("correct reply did not clear the lamp");
	a_fail_pattern: assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce && configured && chan_state == CH_FAIL && flash_phase |=>
		lamps.chan == ~$past(chan_sel))
		else $error("failure pattern is not the inverted channel");
	a_fail_holds: assert property (@(posedge aclk)
		disable iff (!aresetn)
		chan_state == CH_FAIL && configured && !hart.request |=>
		chan_state == CH_FAIL)
		else $error("failure indication dropped without a new request");
	a_cfg_write: assert property (@(posedge aclk)
		disable iff (!aresetn)
		ce && wr_cfg && w_strb[0] |=>
		configured == $past(w_data[0]) &&
		force_err == $past(w_data[1]))
		else $error("configuration write not stored");
endmodule : hidled_top
`default_nettype wire

/* File: verif/hidled_far_model.sv */
// Controller link and field converter stand-in driving activity strobes
`timescale 1ns/10ps
`default_nettype none
module hidled_far_model #(
	parameter int PERIOD = 5
) (
	input  wire logic aclk,
	input  wire logic ctrl_on,
	input  wire logic field_on,
	output wire logic ctrl_activity,
	output wire logic eoc
);
	int   cnt = 0;
	logic act_q = 1'b0;
	logic eoc_q = 1'b0;

	assign ctrl_activity = act_q;
	assign eoc           = eoc_q;

	// Strobes stop dead when switched off, as a lost link or supply would
	always @(posedge aclk) begin
		cnt <= (cnt + 1) % PERIOD;
		act_q <= ctrl_on && (cnt == 0);
		if (field_on && cnt == 0) begin
			eoc_q <= ~eoc_q;
		end
	end
endmodule : hidled_far_model
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench for the diagnostic lamp block
`timescale 1ns/10ps
`default_nettype none
module tb_top;
	import hidled_pkg::*;
	logic             aclk = 1'b0;
	logic             aresetn = 1'b0;
	logic             ctrl_on = 1'b0;
	logic             field_on = 1'b0;
	logic             ctrl_activity;
	logic             eoc;
	hidled_diag_type  diag = '0;
	hidled_hart_type  hart = '0;
	hidled_lamps_type lamps;
	logic             irq;
	logic             ce = 1'b1;
	logic [3:0]       wstrb = 4'hf;
	logic [7:0]       awaddr = '0;
	logic [7:0]       araddr = '0;
	logic [31:0]      wdata = '0;
	logic             awvalid = 1'b0;
	logic             wvalid = 1'b0;
	logic             bready = 1'b0;
	logic             arvalid = 1'b0;
	logic             rready = 1'b0;
	logic             awready, wready, bvalid, arready, rvalid;
	logic [1:0]       bresp, rresp;
	logic [31:0]      rdata;
	logic [31:0]      rd;
	logic [1:0]       rs;
	int               miscompares = 0;
	int               n_tests = 0;
	int               cycles = 0;

	always #50 aclk = ~aclk;

	hidled_far_model #(.PERIOD(5)) far_u (.aclk(aclk), .ctrl_on(ctrl_on),
		.field_on(field_on), .ctrl_activity(ctrl_activity), .eoc(eoc));

	hidled_top #(.COMM_CYCLES(20), .EOC_CYCLES(20), .FLASH_CYCLES(4)) dut_u (
		.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.ctrl_activity(ctrl_activity), .eoc(eoc), .diag(diag), .hart(hart),
		.lamps(lamps), .irq(irq), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready));

	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : stop_test

	// Hang guard, well above the several hundred cycles the run needs
	always @(posedge aclk) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			stop_test();
		end
	end

	task automatic chk(input string name, input logic [31:0] seen,
		input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge aclk);
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] exp_resp);
		bit aw, w, b;
		aw = 0;
		w = 0;
		b = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!b) begin
			@(posedge aclk);
			if (aw && w && bvalid) begin
				b = 1;
				bready <= 1'b0;
				chk("bresp", {30'h0, bresp}, {30'h0, exp_resp});
			end
			if (!aw && awready) begin
				aw = 1;
				awvalid <= 1'b0;
			end
			if (!w && wready) begin
				w = 1;
				wvalid <= 1'b0;
			end
		end
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		bit ar, r;
		ar = 0;
		r = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!r) begin
			@(posedge aclk);
			if (ar && rvalid) begin
				r = 1;
				rd = rdata;
				rs = rresp;
				rready <= 1'b0;
			end
			if (!ar && arready) begin
				ar = 1;
				arvalid <= 1'b0;
			end
		end
	endtask : rdr

	task automatic hart_ev(input logic rq, input logic ok, input logic fl,
		input logic [2:0] ch);
		@(posedge aclk);
		hart <= '{request: rq, reply_ok: ok, fail: fl, channel: ch};
		@(posedge aclk);
		hart <= '0;
		cyc(3);
	endtask : hart_ev

	task automatic t_health;
		ctrl_on <= 1'b1;
		field_on <= 1'b1;
		cyc(60);
		wr(8'h08, 32'h7, 2'b00);
		chk("comm_ok", lamps.comm_ok, 1);
		chk("ext", lamps.ext_fault, 0);
		chk("int", lamps.int_fault, 0);
		rdr(8'h04);
		chk("lamp reg", rd, 32'h400);
		ctrl_on <= 1'b0;
		cyc(40);
		chk("comm_ok", lamps.comm_ok, 0);
		chk("int", lamps.int_fault, 1);
		rdr(8'h08);
		chk("comm loss", rd & 32'h4, 32'h4);
		ctrl_on <= 1'b1;
		field_on <= 1'b0;
		cyc(40);
		chk("ext", lamps.ext_fault, 1);
		chk("int", lamps.int_fault, 0);
		rdr(8'h08);
		chk("field loss", rd & 32'h2, 32'h2);
		field_on <= 1'b1;
		cyc(40);
		chk("ext", lamps.ext_fault, 0);
		wr(8'h08, 32'h7, 2'b00);
	endtask : t_health

	task automatic t_diag;
		for (int i = 0; i < 5; i++) begin
			diag <= hidled_diag_type'(5'h1 << i);
			cyc(4);
			chk("int", lamps.int_fault, 1);
			chk("ext", lamps.ext_fault, 0);
			diag <= '0;
			cyc(4);
			chk("int", lamps.int_fault, 0);
		end
	endtask : t_diag

	task automatic t_force;
		wr(8'h00, 32'h2, 2'b00);
		cyc(3);
		chk("int", lamps.int_fault, 1);
		rdr(8'h00);
		chk("cfg", rd, 32'h2);
		wr(8'h00, 32'h0, 2'b00);
		cyc(3);
		chk("int", lamps.int_fault, 0);
		rdr(8'h10);
		chk("unmapped", {rd[31:2], rs}, 32'h2);
		wr(8'h10, 32'h1, 2'b10);
	endtask : t_force

	task automatic t_chan;
		hart_ev(1'b1, 1'b0, 1'b0, 3'd3);
		chk("unconfigured", lamps.chan, 0);
		wr(8'h00, 32'h1, 2'b00);
		rdr(8'h00);
		chk("cfg", rd, 32'h1);
		for (int ch = 0; ch < 8; ch++) begin
			hart_ev(1'b1, 1'b0, 1'b0, 3'(ch));
			chk("request", lamps.chan, 8'h01 << ch);
			hart_ev(1'b0, 1'b1, 1'b0, 3'(ch));
			chk("reply", lamps.chan, 0);
		end
	endtask : t_chan

	task automatic t_fail;
		int on, off, bad;
		on = 0;
		off = 0;
		bad = 0;
		wr(8'h0c, 32'h0, 2'b00);
		hart_ev(1'b1, 1'b0, 1'b0, 3'd7);
		hart_ev(1'b0, 1'b0, 1'b1, 3'd7);
		chk("fail", lamps.chan, 8'h7f);
		// Flash phase restarts on entry to the failure state; only the two patterns are judged, not their timing
		repeat (24) begin
			@(posedge aclk);
			if (lamps.chan === 8'h7f) begin
				on++;
			end else if (lamps.chan === 8'h00) begin
				off++;
			end else begin
				bad++;
			end
		end
		chk("flash", {on > 0, off > 0, bad == 0}, 3'b111);
		chk("masked irq", irq, 0);
		rdr(8'h08);
		chk("irq stat", rd, 32'h1);
		wr(8'h0c, 32'h1, 2'b00);
		cyc(2);
		chk("irq", irq, 1);
		wr(8'h08, 32'h1, 2'b00);
		cyc(2);
		chk("irq", irq, 0);
		hart_ev(1'b1, 1'b0, 1'b0, 3'd0);
		chk("new cycle", lamps.chan, 8'h01);
	endtask : t_fail

	// Clock enable low must freeze lamps, sequencer and watchdogs
	task automatic t_freeze;
		hart_ev(1'b1, 1'b0, 1'b0, 3'd2);
		ce <= 1'b0;
		ctrl_on <= 1'b0;
		hart_ev(1'b0, 1'b1, 1'b0, 3'd2);
		cyc(40);
		chk("frozen chan", lamps.chan, 8'h04);
		chk("frozen comm", lamps.comm_ok, 1);
		ce <= 1'b1;
		ctrl_on <= 1'b1;
		hart_ev(1'b0, 1'b1, 1'b0, 3'd2);
		chk("reply after freeze", lamps.chan, 0);
		wstrb <= 4'he;
		wr(8'h00, 32'h0, 2'b00);
		wstrb <= 4'hf;
		rdr(8'h00);
		chk("lane 0 off", rd, 32'h1);
	endtask : t_freeze

	task automatic t_reset;
		aresetn <= 1'b0;
		cyc(20);
		aresetn <= 1'b1;
		cyc(2);
		chk("chan after reset", lamps.chan, 0);
		chk("irq after reset", irq, 0);
		rdr(8'h00);
		chk("cfg after reset", rd & 32'h1, 32'h0);
	endtask : t_reset

	initial begin
		cyc(20);
		aresetn <= 1'b1;
		cyc(2);
		rdr(8'h00);
		// No controller traffic yet, so the internal error bit is set
		chk("cfg reset", rd, 32'h2);
		chk("irq reset", irq, 0);
		t_health();
		t_diag();
		t_force();
		t_chan();
		t_freeze();
		t_fail();
		t_reset();
		stop_test();
	end
endmodule : tb_top
`default_nettype wire
